// file: design/tdc_cfg_consts.vh
// constants for the input channel configuration block
`ifndef TDC_CFG_CONSTS_VH
`define TDC_CFG_CONSTS_VH
// register addresses
`define ADDR_PIN_ENABLE_CONTROL 5'h00
`define ADDR_CHANNEL_SETUP_CONTROL 5'h01
// reset values
`define RST_PIN_ENABLE_CONTROL 8'h00
`define RST_CHANNEL_SETUP_CONTROL 8'h00
// pin enable control fields
`define FLD_STOP_PIN_LSB 0
`define FLD_STOP_PIN_MSB 3
`define FLD_REFERENCE_CLOCK_INPUT_EN 4
`define FLD_OUT_DRV_EN 5
`define FLD_INHIBIT_EN 6
`define FLD_IDXRST_EN 7
// channel setup control fields
`define FLD_ACCEPT_LSB 0
`define FLD_ACCEPT_MSB 3
`define FLD_PAIR_LSB 4
`define FLD_PAIR_MSB 5
`define FLD_HIRES_LSB 6
`define FLD_HIRES_MSB 7
// pairing modes
`define PAIR_INDEPENDENT 2'h0
`define PAIR_DISTANCE 2'h1
`define PAIR_WIDTH 2'h2
// high resolution codes and repeat counts
`define HIRES_OFF 2'h0
`define HIRES_2X 2'h1
`define HIRES_4X 2'h2
`define REPEAT_1 3'h1
`define REPEAT_2 3'h2
`define REPEAT_4 3'h4
// serial command byte: bits 7:6 operation, bits 4:0 start address
`define OPC_WRITE 2'h2
`define OPC_READ 2'h1
`define OPC_OP_MSB 7
`define OPC_OP_LSB 6
`define OPC_ADDR_MSB 4
`define OPC_ADDR_LSB 0
`endif

// file: design/tdc_input_channel_config.v
// pin enable and channel setup registers with serial access and stop routing
`include "tdc_cfg_consts.vh"

module tdc_input_channel_config (
    // clock and reset
    input wire clk,
    input wire nrst,
    // serial register port
    input wire sck,
    input wire ssnN,
    input wire mosi,
    output reg miso,
    output wire misoOeN,
    // external pins
    input wire [3:0] stopInput,
    input wire inhibitPin,
    input wire indexResetPin,
    // pin activation
    output wire [3:0] stopInputPinEnable,
    output wire referenceClockInputEnable,
    output wire linkClockEnable,
    output wire [3:0] serialResultOutEnable,
    output wire [3:0] resultFrameOutEnable,
    // measurement control
    output reg [3:0] channelEvent,
    output reg indexCounterReset,
    output reg [2:0] measureRepeat
);

    reg [7:0] pinEnableControl_q;
    reg [7:0] channelSetupControl_q;

    // two-flop synchronisers for every pin input, plus one stage for edges on sck, ssnN and the stop inputs
    reg [2:0] sckSync_q, ssnSync_q, mosiSync_q;
    reg [3:0] stopMeta_q, stopSync_q, stopPrev_q;
    reg [1:0] inhSync_q, idxSync_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sckSync_q <= 3'h0;
            ssnSync_q <= 3'h7;
            mosiSync_q <= 3'h0;
            stopMeta_q <= 4'h0;
            stopSync_q <= 4'h0;
            stopPrev_q <= 4'h0;
            inhSync_q <= 2'h0;
            idxSync_q <= 2'h0;
        end else begin
            sckSync_q <= {sckSync_q[1:0], sck};
            ssnSync_q <= {ssnSync_q[1:0], ssnN};
            mosiSync_q <= {mosiSync_q[1:0], mosi};
            stopMeta_q <= stopInput;
            stopSync_q <= stopMeta_q;
            stopPrev_q <= stopSync_q;
            inhSync_q <= {inhSync_q[0], inhibitPin};
            idxSync_q <= {idxSync_q[0], indexResetPin};
        end
    end

    // edges seen on the second synchroniser stage only
    wire sckRise = sckSync_q[1] & ~sckSync_q[2];
    wire sckFall = ~sckSync_q[1] & sckSync_q[2];
    wire frameOn = ~ssnSync_q[1];
    wire frameStart = ~ssnSync_q[1] & ssnSync_q[2];
    wire mosiBit = mosiSync_q[1];

    // serial engine: command byte, then data bytes with auto increment
    reg [2:0] bitCnt_q;
    reg [7:0] shiftIn_q;
    reg [7:0] shiftOut_q;
    reg cmdDone_q;
    reg isWrite_q;
    reg isRead_q;
    reg [4:0] addr_q;
    wire [7:0] rxByte = {shiftIn_q[6:0], mosiBit};
    wire byteDone = sckRise & (bitCnt_q == 3'h7);
    wire [4:0] cmdAddr = rxByte[`OPC_ADDR_MSB:`OPC_ADDR_LSB];
    wire [1:0] cmdOp = rxByte[`OPC_OP_MSB:`OPC_OP_LSB];

    // read mux; unmapped addresses read as zero
    function [7:0] readReg;
        input [4:0] a;
        begin
            if (a == `ADDR_PIN_ENABLE_CONTROL)
                readReg = pinEnableControl_q;
            else if (a == `ADDR_CHANNEL_SETUP_CONTROL)
                readReg = channelSetupControl_q;
            else
                readReg = 8'h00;
        end
    endfunction

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bitCnt_q <= 3'h0;
            shiftIn_q <= 8'h00;
            shiftOut_q <= 8'h00;
            cmdDone_q <= 1'b0;
            isWrite_q <= 1'b0;
            isRead_q <= 1'b0;
            addr_q <= 5'h00;
            miso <= 1'b0;
        end else if (!frameOn || frameStart) begin
            bitCnt_q <= 3'h0;
            cmdDone_q <= 1'b0;
            isWrite_q <= 1'b0;
            isRead_q <= 1'b0;
            miso <= 1'b0;
        end else begin
            if (sckRise) begin
                shiftIn_q <= rxByte;
                bitCnt_q <= bitCnt_q + 3'h1;
            end
            if (byteDone && !cmdDone_q) begin
                cmdDone_q <= 1'b1;
                isWrite_q <= (cmdOp == `OPC_WRITE);
                isRead_q <= (cmdOp == `OPC_READ);
                addr_q <= cmdAddr;
                shiftOut_q <= readReg(cmdAddr);
            end else if (byteDone) begin
                // next byte of an incremental access
                addr_q <= addr_q + 5'h01;
                shiftOut_q <= readReg(addr_q + 5'h01);
            end else if (sckFall && isRead_q) begin
                // msb first, changed on the falling edge for the host to sample on rising
                miso <= shiftOut_q[7];
                shiftOut_q <= {shiftOut_q[6:0], 1'b0};
            end
        end
    end
    // drive only during a frame; low enable means driving
    assign misoOeN = ~(frameOn & isRead_q);

    // register writes take the completed data byte
    wire wrByte = byteDone & cmdDone_q & isWrite_q & frameOn & ~frameStart;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinEnableControl_q <= `RST_PIN_ENABLE_CONTROL;
            channelSetupControl_q <= `RST_CHANNEL_SETUP_CONTROL;
        end else if (wrByte) begin
            if (addr_q == `ADDR_PIN_ENABLE_CONTROL)
                pinEnableControl_q <= rxByte;
            else if (addr_q == `ADDR_CHANNEL_SETUP_CONTROL)
                channelSetupControl_q <= rxByte;
        end
    end

    // field views
    wire [3:0] stopPinEn = pinEnableControl_q[`FLD_STOP_PIN_MSB:`FLD_STOP_PIN_LSB];
    wire outDrvEn = pinEnableControl_q[`FLD_OUT_DRV_EN];
    wire inhibitEn = pinEnableControl_q[`FLD_INHIBIT_EN];
    wire idxRstEn = pinEnableControl_q[`FLD_IDXRST_EN];
    wire [3:0] accept = channelSetupControl_q[`FLD_ACCEPT_MSB:`FLD_ACCEPT_LSB];
    wire [1:0] pairMode = channelSetupControl_q[`FLD_PAIR_MSB:`FLD_PAIR_LSB];
    wire [1:0] hiRes = channelSetupControl_q[`FLD_HIRES_MSB:`FLD_HIRES_LSB];
    wire paired = (pairMode == `PAIR_DISTANCE) | (pairMode == `PAIR_WIDTH);

    // pin activation straight from the enable bits
    assign stopInputPinEnable = stopPinEn;
    assign referenceClockInputEnable = pinEnableControl_q[`FLD_REFERENCE_CLOCK_INPUT_EN];
    assign linkClockEnable = outDrvEn;

    // a channel's data and frame pins follow the pin that feeds it
    wire [3:0] chanSrcEn = paired ? {stopPinEn[1], stopPinEn[0], stopPinEn[1:0]} : stopPinEn;
    assign serialResultOutEnable = {4{outDrvEn}} & chanSrcEn;
    assign resultFrameOutEnable = {4{outDrvEn}} & chanSrcEn;

    // inhibit stalls every channel while the pin is high
    wire stopsAllowed = ~(inhibitEn & inhSync_q[1]);

    // stop edges from synchronised, enabled inputs; a disabled pin sees nothing
    wire [3:0] stopRise = stopSync_q & ~stopPrev_q & stopPinEn;
    wire [3:0] stopFallE = ~stopSync_q & stopPrev_q & stopPinEn;

    // alternation toggles, one per first and second input
    reg [1:0] altSel_q;
    reg [3:0] route;
    integer i;
    always @* begin
        route = 4'h0;
        if (pairMode == `PAIR_DISTANCE) begin
            for (i = 0; i < 2; i = i + 1) begin
                route[i] = stopRise[i] & ~altSel_q[i];
                route[i + 2] = stopRise[i] & altSel_q[i];
            end
        end else if (pairMode == `PAIR_WIDTH) begin
            route = {stopFallE[1:0], stopRise[1:0]};
        end else begin
            route = stopRise;
        end
    end

    // toggles advance on each event so channels share the input fairly
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            altSel_q <= 2'h0;
        end else if (pairMode != `PAIR_DISTANCE) begin
            altSel_q <= 2'h0;
        end else begin
            altSel_q <= altSel_q ^ stopRise[1:0];
        end
    end

    // registered outputs; code 3 in either field is left to the host to avoid
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            channelEvent <= 4'h0;
            indexCounterReset <= 1'b0;
            measureRepeat <= `REPEAT_1;
        end else begin
            channelEvent <= route & accept & {4{stopsAllowed}};
            indexCounterReset <= idxRstEn & idxSync_q[1];
            case (hiRes)
                `HIRES_2X: measureRepeat <= `REPEAT_2;
                `HIRES_4X: measureRepeat <= `REPEAT_4;
                default: measureRepeat <= `REPEAT_1;
            endcase
        end
    end

endmodule

// file: test/spi_host_model.sv
// serial host model that configures the block
module spi_host_model (
    // clock
    input wire logic clk,
    // serial lines
    output logic sck,
    output logic ssnN,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck = 1'b0;
        ssnN = 1'b1;
        mosi = 1'b0;
    end
    // one byte msb first; six clocks a phase, since the pins are synchronised
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi <= tx[i];
            repeat (6) @(posedge clk);
            sck <= 1'b1;
            rx[i] = miso;
            repeat (6) @(posedge clk);
            sck <= 1'b0;
        end
    endtask
    // command byte, then two data bytes at rising addresses
    task automatic frame(input logic [7:0] cmd, input logic [15:0] tx, output logic [15:0] rx);
        logic [7:0] junk;
        ssnN <= 1'b0;
        repeat (6) @(posedge clk);
        xb(cmd, junk);
        xb(tx[15:8], rx[15:8]);
        xb(tx[7:0], rx[7:0]);
        repeat (6) @(posedge clk);
        ssnN <= 1'b1;
        mosi <= ~mosi;  // no stale level after release
        repeat (6) @(posedge clk);
    endtask
endmodule

// file: test/tdc_input_channel_config_asserts.sv
// concurrent checks on the configuration block ports
module tdc_cfg_checker (
    // clock and reset
    input wire clk,
    input wire nrst,
    // watched ports
    input wire ssnN,
    input wire misoOeN,
    input wire indexResetPin,
    input wire indexCounterReset,
    input wire linkClockEnable,
    input wire [3:0] stopInputPinEnable,
    input wire [3:0] serialResultOutEnable,
    input wire [3:0] resultFrameOutEnable,
    input wire [3:0] channelEvent,
    input wire [2:0] measureRepeat
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    link_gate_a: assert property (!linkClockEnable |-> serialResultOutEnable == 4'h0)
        else $error("data outputs on with drivers off");
    frame_pair_a: assert property (resultFrameOutEnable[1:0] == ({2{linkClockEnable}} & stopInputPinEnable[1:0]))
        else $error("frame enables do not follow their pins");
    data_src_a: assert property (serialResultOutEnable[1:0] == ({2{linkClockEnable}} & stopInputPinEnable[1:0]))
        else $error("data enables do not follow their pins");
    idx_gate_a: assert property (indexCounterReset |-> $past(indexResetPin, 3))
        else $error("index reset without pin");
    pulse_one_a: assert property ((channelEvent & $past(channelEvent)) == 4'h0)
        else $error("event pulse longer than a cycle");
    pin_cause_a: assert property ((channelEvent[1:0] & ~$past(stopInputPinEnable[1:0])) == 2'h0)
        else $error("event from a disabled pin");
    rep_code_a: assert property (measureRepeat == 3'h1 || measureRepeat == 3'h2 || measureRepeat == 3'h4)
        else $error("illegal repeat count");
    oe_idle_a: assert property (ssnN [*6] |-> misoOeN)
        else $error("serial output driven outside frame");
    cfg_hold_a: assert property (ssnN [*6] |-> $stable(stopInputPinEnable))
        else $error("pin enables changed outside frame");
    // main scenarios reached
    cover property (channelEvent[2]);
    cover property (measureRepeat == 3'h4);
    cover property (indexCounterReset);
    cover property (!misoOeN);
endmodule
bind tdc_input_channel_config tdc_cfg_checker chk_i (.clk, .nrst, .ssnN, .misoOeN, .indexResetPin,
    .indexCounterReset, .linkClockEnable, .stopInputPinEnable, .serialResultOutEnable,
    .resultFrameOutEnable, .channelEvent, .measureRepeat);

// file: test/tb_tdc_input_channel_config.sv
// self-checking bench for the input channel configuration block
module tb_tdc_input_channel_config;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, inhibitPin, indexResetPin;
    logic [3:0] stopInput;
    logic [15:0] rx;
    wire sck, ssnN, mosi, miso, misoOeN, referenceClockInputEnable, linkClockEnable, indexCounterReset;
    wire [3:0] stopInputPinEnable, serialResultOutEnable, resultFrameOutEnable, channelEvent;
    wire [2:0] measureRepeat;
    int n_errors = 0;
    int n_compared = 0;
    tdc_input_channel_config uut (.clk, .nrst, .sck, .ssnN, .mosi, .miso, .misoOeN, .stopInput, .inhibitPin,
        .indexResetPin, .stopInputPinEnable, .referenceClockInputEnable, .linkClockEnable,
        .serialResultOutEnable, .resultFrameOutEnable, .channelEvent, .indexCounterReset, .measureRepeat);
    spi_host_model host (.clk, .sck, .ssnN, .mosi, .miso);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d of %0d compared", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // both registers in one burst from address 0; host keeps code 3 out of both fields
    task automatic wr(input logic [15:0] v);
        host.frame(8'h80, v, rx);
    endtask
    // two pulses on one stop pin, two-bit event count per channel
    task automatic burst(input string what, input logic [1:0] pin, input logic [7:0] exp);
        logic [1:0] c [4];
        c = '{default: 2'h0};
        for (int t = 0; t < 40; t++) begin
            @(posedge clk);
            stopInput <= ((t < 12) && (t % 8 < 4)) ? (4'h1 << pin) : 4'h0;
            @(negedge clk);
            for (int i = 0; i < 4; i++)
                c[i] += channelEvent[i];
        end
        // back on the rising edge so the next stimulus lands there
        @(posedge clk);
        chk(what, {8'h00, exp}, {8'h00, c[3], c[2], c[1], c[0]});
    endtask
    task automatic t_reset;
        chk("reset outputs", 16'h0009, {stopInputPinEnable, serialResultOutEnable, channelEvent, misoOeN,
            measureRepeat});
        host.frame(8'h40, 16'h0000, rx);
        chk("reset regs", 16'h0000, rx);
    endtask
    task automatic t_regs;
        wr(16'h5a96);
        host.frame(8'h40, 16'h0000, rx);
        chk("readback", 16'h5a96, rx);
        host.frame(8'h41, 16'h0000, rx);
        chk("unmapped", 16'h9600, rx);
    endtask
    task automatic t_pins;
        wr(16'h2f00);
        chk("enables 2f", 16'hfff2, {stopInputPinEnable, serialResultOutEnable, resultFrameOutEnable, 2'h0,
            linkClockEnable, referenceClockInputEnable});
        wr(16'h1f00);
        chk("enables 1f", 16'hf001, {stopInputPinEnable, serialResultOutEnable, resultFrameOutEnable, 2'h0,
            linkClockEnable, referenceClockInputEnable});
        wr(16'h2113);
        chk("enables paired", 16'h1552, {stopInputPinEnable, serialResultOutEnable, resultFrameOutEnable, 2'h0,
            linkClockEnable, referenceClockInputEnable});
    endtask
    task automatic t_events;
        wr(16'h0f0f);
        burst("mode 00", 2'h0, 8'h02);
        burst("mode 00 s4", 2'h3, 8'h80);
        wr(16'h0f1f);
        burst("mode 01", 2'h0, 8'h11);
        burst("mode 01 s2", 2'h1, 8'h44);
        wr(16'h0f2f);
        burst("mode 10", 2'h0, 8'h22);
        burst("mode 10 s2", 2'h1, 8'h88);
        wr(16'h0f0e);
        burst("accept off", 2'h0, 8'h00);
        wr(16'h0e0f);
        burst("pin off", 2'h0, 8'h00);
        inhibitPin <= 1'b1;
        wr(16'h4f0f);
        burst("inhibit on", 2'h0, 8'h00);
        wr(16'h0f0f);
        burst("inhibit unused", 2'h0, 8'h02);
        inhibitPin <= 1'b0;
    endtask
    task automatic t_hires;
        for (int k = 0; k < 3; k++) begin
            wr({8'h00, 2'(k), 6'h0f});
            chk("repeat", 16'h0001 << k, {13'h0, measureRepeat});
        end
    endtask
    task automatic t_index;
        indexResetPin <= 1'b1;
        wr(16'h0000);
        chk("index gated", 16'h0000, {15'h0, indexCounterReset});
        wr(16'h8000);
        chk("index on", 16'h0001, {15'h0, indexCounterReset});
        indexResetPin <= 1'b0;
        repeat (5) @(posedge clk);
        chk("index off", 16'h0000, {15'h0, indexCounterReset});
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // a hang counts as a mismatch
    initial begin
        #150us;
        n_errors++;
        give_verdict();
    end
    initial begin
        nrst = 1'b0;
        stopInput = 4'h0;
        inhibitPin = 1'b0;
        indexResetPin = 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_pins();
        t_events();
        t_hires();
        t_index();
        give_verdict();
    end
endmodule
